// >>> rtl/power_clock_mode_ctrl.sv
// Purpose: Reset, clock source, boot latch and low-power mode sequencer
// Assumes: Analog comparators and pins arrive asynchronously; core requests share REF_CLK
// Notes:   APB slave with zero wait states; clock outputs are enables, not clocks
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// (RULE_01) Every reset leaves the core running from the internal 8 MHz RC.
// (RULE_02) Software may pick the 4-16 MHz external clock; it is then watched.
// (RULE_03) A failed external clock returns the system clock to the RC by itself.
// (RULE_04) Clock failure raises an interrupt only when its enable is set.
// (RULE_05) Three prescalers; AHB and fast APB at most 72 MHz, slow 36 MHz.
// (RULE_06) Boot pins are sampled at startup: Flash, system memory or SRAM.
// (RULE_07) Flash boot uses bank 1, bank 2 when the option bit is set.
// (RULE_08) Power-on/power-down reset always holds the chip while supply is low.
// (RULE_09) Enabled supply detector interrupts on falling, rising or both crossings.
// (RULE_10) Regulator main in Run, main or low-power in Stop, off in Standby.
// (RULE_11) Regulator on after reset, off only during Standby.
// (RULE_12) Sleep gates only the processor clock; any interrupt or event resumes.
// (RULE_13) Stop halts core clocks, PLL and fast oscillators, keeping state.
// (RULE_14) Stop exits on enabled event lines, detector, RTC alarm or USB.
// (RULE_15) Standby powers off core, oscillators and PLL; core state is lost.
// (RULE_16) Standby exits on reset pin, watchdog reset, wakeup rise or RTC alarm.
// (RULE_17) RTC, watchdog and their slow clocks keep running in Stop and Standby.
// (RULE_18) Leaving Standby runs the full reset sequence again.
module power_clock_mode_ctrl (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SUPPLY_BELOW_RESET,
  input  wire logic        SUPPLY_BELOW_DETECT,
  input  wire logic        EXT_CLK_SAMPLE,
  input  wire logic        EXTERNAL_RESET_PIN_N,
  input  wire logic        WATCHDOG_RESET,
  input  wire logic        WAKEUP_PIN,
  input  wire logic        RTC_ALARM,
  input  wire logic        USB_WAKEUP,
  input  wire logic [1:0]  BOOT_SEL,
  input  wire logic        BANK2_OPTION,
  input  wire logic [15:0] EXTERNAL_EVENT_LINE,
  input  wire logic        CPU_SLEEP_REQ,
  input  wire logic        CPU_WAKE_EVENT,
  output logic             SYS_RESET_N,
  output logic             CPU_CLK_EN,
  output logic             AHB_CLK_EN,
  output logic             APB_FAST_CLK_EN,
  output logic             APB_SLOW_CLK_EN,
  output logic             SYSCLK_SEL_EXT,
  output logic             INTERNAL_FAST_RC_EN,
  output logic             EXTERNAL_FAST_OSC_EN,
  output logic             PLL_EN,
  output logic             MAIN_REGULATOR_EN,
  output logic             LOW_POWER_REGULATOR_EN,
  output logic             REGULATOR_HIGH_Z,
  output logic             LOW_SPEED_DOMAIN_RUN,
  output logic [1:0]       BOOT_TARGET,
  output logic             BOOT_BANK2,
  output logic [2:0]       MODE_STATE,
  output logic             IRQ
);

  // ----
  // Input synchronisers
  // ----
  logic [pcm_pkg::SYNC_W-1:0] async_in;
  logic [pcm_pkg::SYNC_W-1:0] sync1_ff;
  logic [pcm_pkg::SYNC_W-1:0] sync2_ff;

  assign async_in = {EXTERNAL_EVENT_LINE, BANK2_OPTION, BOOT_SEL[1], BOOT_SEL[0], USB_WAKEUP,
                     RTC_ALARM, WAKEUP_PIN, WATCHDOG_RESET, EXTERNAL_RESET_PIN_N,
                     EXT_CLK_SAMPLE, SUPPLY_BELOW_DETECT, SUPPLY_BELOW_RESET};

  genvar gi;
  generate
    for (gi = 0; gi < pcm_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= async_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  logic        por_low;
  logic        det_low;
  logic        xrst_active;
  logic        wdg_rst;
  logic        rtc_alarm;
  logic [15:0] evt_lines;
  assign por_low     = sync2_ff[pcm_pkg::SY_POR];
  assign det_low     = sync2_ff[pcm_pkg::SY_DET];
  assign xrst_active = !sync2_ff[pcm_pkg::SY_XRSTN];
  assign wdg_rst     = sync2_ff[pcm_pkg::SY_WDG];
  assign rtc_alarm   = sync2_ff[pcm_pkg::SY_RTC];
  assign evt_lines   = sync2_ff[pcm_pkg::SY_EVT +: 16];

  // ----
  // Registers and APB decode
  // ----
  pcm_pkg::clk_cfg_t    clk_cfg_ff;
  pcm_pkg::pwr_cfg_t    pwr_cfg_ff;
  pcm_pkg::wake_t       wake_en_ff;
  logic [pcm_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [pcm_pkg::IRQ_W-1:0] irq_en_ff;
  logic [pcm_pkg::IRQ_W-1:0] nxt_irq_stat;
  logic [pcm_pkg::IRQ_W-1:0] irq_set;
  logic [pcm_pkg::IRQ_W-1:0] irq_clr;
  pcm_pkg::mode_state_t state_ff;
  pcm_pkg::mode_state_t nxt_state;
  logic        sysclk_ext_ff;
  logic [1:0]  boot_target_ff;
  logic        bank2_ff;
  logic        standby_wake_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_word;
  logic        mapped;
  logic        wr_en;
  logic        in_reset;

  assign wr_en    = PSEL && PENABLE && PWRITE;
  assign in_reset = (state_ff == pcm_pkg::ST_RESET);

  always_comb begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    if (PADDR == pcm_pkg::OFS_CLK_CTRL) begin
      rd_word[pcm_pkg::CLK_CFG_W-1:0] = clk_cfg_ff;
    end else if (PADDR == pcm_pkg::OFS_PWR_CTRL) begin
      rd_word[pcm_pkg::PWR_CFG_W-1:0] = pwr_cfg_ff;
    end else if (PADDR == pcm_pkg::OFS_STATUS) begin
      rd_word[9:0] = {standby_wake_ff, det_low, bank2_ff, boot_target_ff,
                      state_ff, 1'b0, sysclk_ext_ff};
    end else if (PADDR == pcm_pkg::OFS_IRQ_STAT) begin
      rd_word[pcm_pkg::IRQ_W-1:0] = irq_stat_ff;
    end else if (PADDR == pcm_pkg::OFS_IRQ_CLR) begin
      rd_word = 32'h0000_0000;
    end else if (PADDR == pcm_pkg::OFS_IRQ_EN) begin
      rd_word[pcm_pkg::IRQ_W-1:0] = irq_en_ff;
    end else if (PADDR == pcm_pkg::OFS_WAKE_EN) begin
      rd_word[pcm_pkg::WAKE_W-1:0] = wake_en_ff;
    end else begin
      mapped = 1'b0;
    end
  end

  // Read data captured in the setup cycle so it sits in a flop at access
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_ff <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      prdata_ff <= rd_word;
    end
  end

  assign PRDATA  = prdata_ff;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Configuration is core state: lost in Standby, so reset state clears it
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      clk_cfg_ff <= pcm_pkg::CLK_CFG_RST;
      pwr_cfg_ff <= pcm_pkg::PWR_CFG_RST;
      wake_en_ff <= pcm_pkg::WAKE_RST;
      irq_en_ff  <= pcm_pkg::IRQ_RST;
    end else if (in_reset) begin
      clk_cfg_ff <= pcm_pkg::CLK_CFG_RST; // [RULE_18]
      pwr_cfg_ff <= pcm_pkg::PWR_CFG_RST;
      wake_en_ff <= pcm_pkg::WAKE_RST;
      irq_en_ff  <= pcm_pkg::IRQ_RST;
    end else if (wr_en) begin
      if (PADDR == pcm_pkg::OFS_CLK_CTRL) begin
        clk_cfg_ff <= PWDATA[pcm_pkg::CLK_CFG_W-1:0];
      end else if (PADDR == pcm_pkg::OFS_PWR_CTRL) begin
        pwr_cfg_ff <= PWDATA[pcm_pkg::PWR_CFG_W-1:0];
      end else if (PADDR == pcm_pkg::OFS_IRQ_EN) begin
        irq_en_ff <= PWDATA[pcm_pkg::IRQ_W-1:0];
      end else if (PADDR == pcm_pkg::OFS_WAKE_EN) begin
        wake_en_ff <= PWDATA[pcm_pkg::WAKE_W-1:0];
      end
    end
  end

  // ----
  // External clock monitor
  // ----
  logic       extck_d_ff;
  logic       ext_seen_ff;
  logic [7:0] mon_cnt_ff;
  logic       ext_edge;
  logic       mon_expired;
  logic       ext_alive;
  logic       clk_fail;

  assign ext_edge    = sync2_ff[pcm_pkg::SY_EXTCK] ^ extck_d_ff;
  assign mon_expired = (mon_cnt_ff == 8'(pcm_pkg::MON_CYC));
  assign ext_alive   = ext_seen_ff && !mon_expired;
  assign clk_fail    = sysclk_ext_ff && mon_expired; // [RULE_02]

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      extck_d_ff  <= 1'b0;
      ext_seen_ff <= 1'b0;
      mon_cnt_ff  <= 8'h00;
    end else begin
      extck_d_ff <= sync2_ff[pcm_pkg::SY_EXTCK];
      if (!EXTERNAL_FAST_OSC_EN) begin
        ext_seen_ff <= 1'b0;
        mon_cnt_ff  <= 8'h00;
      end else if (ext_edge) begin
        ext_seen_ff <= 1'b1;
        mon_cnt_ff  <= 8'h00;
      end else if (!mon_expired) begin
        mon_cnt_ff <= mon_cnt_ff + 8'h01;
      end
    end
  end

  // Switch to the external source only once it is seen toggling
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sysclk_ext_ff <= 1'b0;
    end else if (in_reset || nxt_state == pcm_pkg::ST_RESET) begin
      sysclk_ext_ff <= 1'b0; // [RULE_01]
    end else if (clk_fail) begin
      sysclk_ext_ff <= 1'b0; // [RULE_03]
    end else if (state_ff == pcm_pkg::ST_STOP) begin
      sysclk_ext_ff <= 1'b0;
    end else if (wr_en && PADDR == pcm_pkg::OFS_CLK_CTRL) begin
      sysclk_ext_ff <= PWDATA[1] && ext_alive; // [RULE_02]
    end
  end

  // ----
  // Prescalers
  // ----
  logic [2:0][3:0] div_field;
  logic [2:0][3:0] div_min;
  logic [2:0][3:0] div_cnt_ff;
  logic [2:0]      div_tick;

  assign div_field = {clk_cfg_ff.slow_div, clk_cfg_ff.fast_div, clk_cfg_ff.ahb_div};
  assign div_min   = {pcm_pkg::SLOW_DIV_MIN, pcm_pkg::FAST_DIV_MIN, pcm_pkg::AHB_DIV_MIN};

  generate
    for (gi = 0; gi < 3; gi++) begin : g_div
      logic [3:0] ratio;
      // Ratios below the minimum are raised so no domain overruns its limit
      assign ratio        = (div_field[gi] < div_min[gi]) ? div_min[gi] : div_field[gi];
      assign div_tick[gi] = (div_cnt_ff[gi] >= ratio - 4'h1); // [RULE_05]
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          div_cnt_ff[gi] <= 4'h0;
        end else if (div_tick[gi]) begin
          div_cnt_ff[gi] <= 4'h0;
        end else begin
          div_cnt_ff[gi] <= div_cnt_ff[gi] + 4'h1;
        end
      end
    end
  endgenerate

  // ----
  // Supply detector and interrupts
  // ----
  logic det_d_ff;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      det_d_ff <= 1'b0;
    end else begin
      det_d_ff <= det_low;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[pcm_pkg::IRQ_CLK_FAIL] = clk_fail; // [RULE_04]
    irq_set[pcm_pkg::IRQ_FALL] = pwr_cfg_ff.det_en && pwr_cfg_ff.fall_irq
                                 && det_low && !det_d_ff; // [RULE_09]
    irq_set[pcm_pkg::IRQ_RISE] = pwr_cfg_ff.det_en && pwr_cfg_ff.rise_irq
                                 && !det_low && det_d_ff; // [RULE_09]
    irq_clr = '0;
    if (wr_en && PADDR == pcm_pkg::OFS_IRQ_CLR) begin
      irq_clr = PWDATA[pcm_pkg::IRQ_W-1:0];
    end
    // A new event in the clearing cycle survives
    nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat_ff <= pcm_pkg::IRQ_RST;
    end else if (in_reset) begin
      irq_stat_ff <= pcm_pkg::IRQ_RST;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  assign IRQ = |(irq_stat_ff & irq_en_ff); // [RULE_04]

  // ----
  // Mode sequencer
  // ----
  logic       reset_cause;
  logic       wakeup_pin_d_ff;
  logic       wakeup_pin_rise;
  logic       stop_wake;
  logic [7:0] rst_cnt_ff;
  logic       rst_done;

  assign reset_cause = por_low || xrst_active || wdg_rst; // [RULE_08]
  assign wakeup_pin_rise   = sync2_ff[pcm_pkg::SY_WAKEUP_PIN] && !wakeup_pin_d_ff;
  assign stop_wake   = |(evt_lines & wake_en_ff.lines)
                    || (det_low && wake_en_ff.detector)
                    || (rtc_alarm && wake_en_ff.rtc)
                    || (sync2_ff[pcm_pkg::SY_USB] && wake_en_ff.usb); // [RULE_14]
  assign rst_done    = (rst_cnt_ff == 8'(pcm_pkg::RESET_HOLD_CYC));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pcm_pkg::ST_RESET: begin
        if (rst_done) begin
          nxt_state = pcm_pkg::ST_RUN;
        end
      end
      pcm_pkg::ST_RUN: begin
        if (CPU_SLEEP_REQ) begin
          if (pwr_cfg_ff.low_mode == pcm_pkg::LOW_SLEEP) begin
            nxt_state = pcm_pkg::ST_SLEEP;
          end else if (pwr_cfg_ff.low_mode == pcm_pkg::LOW_STOP) begin
            nxt_state = pcm_pkg::ST_STOP;
          end else begin
            nxt_state = pcm_pkg::ST_STANDBY;
          end
        end
      end
      pcm_pkg::ST_SLEEP: begin
        if (CPU_WAKE_EVENT || IRQ) begin
          nxt_state = pcm_pkg::ST_RUN; // [RULE_12]
        end
      end
      pcm_pkg::ST_STOP: begin
        if (stop_wake) begin
          nxt_state = pcm_pkg::ST_RUN; // [RULE_14]
        end
      end
      pcm_pkg::ST_STANDBY: begin
        if (wakeup_pin_rise || rtc_alarm) begin
          nxt_state = pcm_pkg::ST_RESET; // [RULE_16] [RULE_18]
        end
      end
      default: nxt_state = pcm_pkg::ST_RESET;
    endcase
    if (reset_cause) begin
      nxt_state = pcm_pkg::ST_RESET; // [RULE_08] [RULE_16]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff  <= pcm_pkg::ST_RESET;
      wakeup_pin_d_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      wakeup_pin_d_ff <= sync2_ff[pcm_pkg::SY_WAKEUP_PIN];
    end
  end

  // Hold time restarts while any reset cause persists
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_cnt_ff <= 8'h00;
    end else if (!in_reset || reset_cause) begin
      rst_cnt_ff <= 8'h00;
    end else if (!rst_done) begin
      rst_cnt_ff <= rst_cnt_ff + 8'h01;
    end
  end

  // Boot straps caught once, at the release of the internal reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      boot_target_ff <= pcm_pkg::BOOT_FLASH;
      bank2_ff       <= 1'b0;
    end else if (in_reset && nxt_state == pcm_pkg::ST_RUN) begin
      if (!sync2_ff[pcm_pkg::SY_BOOT0]) begin
        boot_target_ff <= pcm_pkg::BOOT_FLASH; // [RULE_06]
      end else if (!sync2_ff[pcm_pkg::SY_BOOT1]) begin
        boot_target_ff <= pcm_pkg::BOOT_SYSMEM;
      end else begin
        boot_target_ff <= pcm_pkg::BOOT_SRAM;
      end
      bank2_ff <= !sync2_ff[pcm_pkg::SY_BOOT0] && sync2_ff[pcm_pkg::SY_BANK]; // [RULE_07]
    end
  end

  // Standby-circuit flag: survives the wake restart, cleared by power loss
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      standby_wake_ff <= 1'b0;
    end else if (por_low) begin
      standby_wake_ff <= 1'b0;
    end else if (state_ff == pcm_pkg::ST_STANDBY && nxt_state == pcm_pkg::ST_RESET) begin
      standby_wake_ff <= 1'b1;
    end
  end

  // ----
  // Outputs
  // ----
  logic core_awake;
  logic standby;

  assign standby    = (state_ff == pcm_pkg::ST_STANDBY);
  assign core_awake = (state_ff != pcm_pkg::ST_STOP) && !standby; // [RULE_13] [RULE_15]

  assign SYS_RESET_N          = !in_reset;
  assign CPU_CLK_EN           = (state_ff == pcm_pkg::ST_RUN) && div_tick[0]; // [RULE_12]
  assign AHB_CLK_EN           = core_awake && div_tick[0]; // [RULE_13]
  assign APB_FAST_CLK_EN      = core_awake && div_tick[1];
  assign APB_SLOW_CLK_EN      = core_awake && div_tick[2];
  assign SYSCLK_SEL_EXT       = sysclk_ext_ff;
  assign INTERNAL_FAST_RC_EN  = core_awake; // [RULE_01] [RULE_13]
  assign EXTERNAL_FAST_OSC_EN = core_awake && clk_cfg_ff.ext_on; // [RULE_15]
  assign PLL_EN               = core_awake && clk_cfg_ff.pll_on; // [RULE_13]
  assign MAIN_REGULATOR_EN    = !standby && !((state_ff == pcm_pkg::ST_STOP)
                                 && pwr_cfg_ff.stop_low_power); // [RULE_10] [RULE_11]
  assign LOW_POWER_REGULATOR_EN = (state_ff == pcm_pkg::ST_STOP)
                                 && pwr_cfg_ff.stop_low_power; // [RULE_10]
  assign REGULATOR_HIGH_Z     = standby; // [RULE_10] [RULE_11]
  assign LOW_SPEED_DOMAIN_RUN = 1'b1; // [RULE_17]
  assign BOOT_TARGET          = boot_target_ff;
  assign BOOT_BANK2           = bank2_ff;
  assign MODE_STATE           = state_ff;

endmodule

`default_nettype wire

// >>> rtl/pcm_pkg.sv
// Purpose: Shared constants and types for the power, clock and mode controller
// Assumes: 125 MHz reference clock, APB register access with 32-bit data
// Notes:   Register offsets are byte addresses on the APB
package pcm_pkg;

  // ----
  // Register map
  // ----
  localparam logic [11:0] OFS_CLK_CTRL = 12'h000;
  localparam logic [11:0] OFS_PWR_CTRL = 12'h004;
  localparam logic [11:0] OFS_STATUS   = 12'h008;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h010;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h014;
  localparam logic [11:0] OFS_WAKE_EN  = 12'h018;

  // ----
  // Register layouts
  // ----
  typedef struct packed {
    logic       pll_on;
    logic [3:0] slow_div;
    logic [3:0] fast_div;
    logic [3:0] ahb_div;
    logic       sel_ext;
    logic       ext_on;
  } clk_cfg_t;

  typedef struct packed {
    logic [1:0] low_mode;
    logic       stop_low_power;
    logic       rise_irq;
    logic       fall_irq;
    logic       det_en;
  } pwr_cfg_t;

  typedef struct packed {
    logic       usb;
    logic       rtc;
    logic       detector;
    logic [15:0] lines;
  } wake_t;

  localparam int CLK_CFG_W = 15;
  localparam int PWR_CFG_W = 6;
  localparam int WAKE_W    = 19;
  localparam int IRQ_W     = 3;

  localparam logic [CLK_CFG_W-1:0] CLK_CFG_RST = 15'h0000;
  localparam logic [PWR_CFG_W-1:0] PWR_CFG_RST = 6'h00;
  localparam logic [WAKE_W-1:0]    WAKE_RST    = 19'h0_0000;
  localparam logic [IRQ_W-1:0]     IRQ_RST     = 3'h0;

  localparam int IRQ_CLK_FAIL = 0;
  localparam int IRQ_FALL     = 1;
  localparam int IRQ_RISE     = 2;

  // Low-power mode field encodings
  localparam logic [1:0] LOW_SLEEP = 2'h0;
  localparam logic [1:0] LOW_STOP  = 2'h1;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_RUN,
    ST_SLEEP,
    ST_STOP,
    ST_STANDBY
  } mode_state_t;

  typedef enum logic [1:0] {
    BOOT_FLASH,
    BOOT_SYSMEM,
    BOOT_SRAM
  } boot_target_t;

  // ----
  // Synchroniser vector positions
  // ----
  localparam int SY_POR   = 0;
  localparam int SY_DET   = 1;
  localparam int SY_EXTCK = 2;
  localparam int SY_XRSTN = 3;
  localparam int SY_WDG   = 4;
  localparam int SY_WAKEUP_PIN  = 5;
  localparam int SY_RTC   = 6;
  localparam int SY_USB   = 7;
  localparam int SY_BOOT0 = 8;
  localparam int SY_BOOT1 = 9;
  localparam int SY_BANK  = 10;
  localparam int SY_EVT   = 11;
  localparam int SYNC_W   = 27;

  // ----
  // Timing
  // ----
  localparam int REF_CLK_MHZ    = 125;
  localparam int REF_PERIOD_NS  = 8;
  localparam int AHB_MAX_MHZ    = 72;
  localparam int FAST_MAX_MHZ   = 72;
  localparam int SLOW_MAX_MHZ   = 36;
  localparam int RESET_HOLD_NS  = 1000;
  localparam int MON_WINDOW_NS  = 2000;
  localparam int RESET_HOLD_CYC = RESET_HOLD_NS / REF_PERIOD_NS;
  localparam int MON_CYC        = MON_WINDOW_NS / REF_PERIOD_NS;
  localparam logic [3:0] AHB_DIV_MIN  = 4'((REF_CLK_MHZ + AHB_MAX_MHZ - 1) / AHB_MAX_MHZ);
  localparam logic [3:0] FAST_DIV_MIN = 4'((REF_CLK_MHZ + FAST_MAX_MHZ - 1) / FAST_MAX_MHZ);
  localparam logic [3:0] SLOW_DIV_MIN = 4'((REF_CLK_MHZ + SLOW_MAX_MHZ - 1) / SLOW_MAX_MHZ);

endpackage

// >>> tb/pcm_sva.sv
// Purpose: Port checks for the power, clock and mode controller
// Assumes: Bound to the top module; one clock domain
// Notes:   A stall counter replaces a long stable-input repeat
`timescale 1ns/1ns
`default_nettype none
module pcm_sva (
  input wire logic       REF_CLK,
  input wire logic       RST_N,
  input wire logic       SUPPLY_BELOW_RESET,
  input wire logic       EXT_CLK_SAMPLE,
  input wire logic       WAKEUP_PIN,
  input wire logic       SYS_RESET_N,
  input wire logic       CPU_CLK_EN,
  input wire logic       SYSCLK_SEL_EXT,
  input wire logic       INTERNAL_FAST_RC_EN,
  input wire logic       EXTERNAL_FAST_OSC_EN,
  input wire logic       PLL_EN,
  input wire logic       MAIN_REGULATOR_EN,
  input wire logic       LOW_POWER_REGULATOR_EN,
  input wire logic       REGULATOR_HIGH_Z,
  input wire logic [2:0] MODE_STATE
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic       prev_ff;
  logic [9:0] stall_ff;
  // Saturates above the bound so a stuck selection still fails
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prev_ff  <= 1'b0;
      stall_ff <= 10'h000;
    end else begin
      prev_ff  <= EXT_CLK_SAMPLE;
      stall_ff <= (prev_ff != EXT_CLK_SAMPLE) ? 10'h000 : stall_ff + 10'(!stall_ff[9]);
    end
  end
  sequence s_stby_rise; MODE_STATE == 3'h4 ##1 $rose(WAKEUP_PIN); endsequence
  sequence s_held; MODE_STATE == 3'h0 && !SYS_RESET_N; endsequence
  property p_rst_rc; !SYS_RESET_N |-> INTERNAL_FAST_RC_EN && !SYSCLK_SEL_EXT; endproperty
  a_rst_rc: assert property (p_rst_rc)
    else $error("Reset without internal RC");
  property p_mon; SYSCLK_SEL_EXT |-> stall_ff < 10'h104; endproperty
  a_mon: assert property (p_mon)
    else $error("Stalled external clock kept");
  property p_por; SUPPLY_BELOW_RESET [*4] |=> !SYS_RESET_N; endproperty
  a_por: assert property (p_por)
    else $error("Low supply without reset");
  property p_run; MODE_STATE == 3'h1 |-> MAIN_REGULATOR_EN && !REGULATOR_HIGH_Z; endproperty
  a_run: assert property (p_run)
    else $error("Run without main regulator");
  property p_reg; MODE_STATE != 3'h4 |-> MAIN_REGULATOR_EN || LOW_POWER_REGULATOR_EN; endproperty
  a_reg: assert property (p_reg)
    else $error("Regulator off outside standby");
  property p_slp; MODE_STATE == 3'h2 |-> !CPU_CLK_EN; endproperty
  a_slp: assert property (p_slp)
    else $error("Processor clock in sleep");
  property p_stop; MODE_STATE == 3'h3 |-> !(PLL_EN || EXTERNAL_FAST_OSC_EN || INTERNAL_FAST_RC_EN);
  endproperty
  a_stop: assert property (p_stop)
    else $error("Oscillator on in stop");
  property p_stby; MODE_STATE == 3'h4 |-> REGULATOR_HIGH_Z && !MAIN_REGULATOR_EN && !PLL_EN;
  endproperty
  a_stby: assert property (p_stby)
    else $error("Core powered in standby");
  property p_wake; s_stby_rise |-> ##[1:8] s_held; endproperty
  a_wake: assert property (p_wake)
    else $error("Wakeup rise ignored in standby");
endmodule
`default_nettype wire

// >>> tb/power_clock_mode_ctrl_tb.sv
// Purpose: Scenario bench for the power, clock and mode controller
// Assumes: 125 MHz clock; APB master with NBA drive
// Notes:   Each scenario judges its own results
`timescale 1ns/1ns
`default_nettype none
module power_clock_mode_ctrl_tb;
  logic        ref_clk, rst_n, psel, penable, pwrite, b_rst, b_det, ext_ck, xrst_n, wdg;
  logic        wakeup_pin, rtc, usb, bank2, slp, wev, ext_run, rdy, err, srst_n, cpu_en, slow_en;
  logic        sel_ext, rc_en, pll_en, mr_en, lpr_en, hiz, lsd, bank2_o, irq;
  logic [1:0]  boot_sel, boot_t;
  logic [2:0]  mode;
  logic [11:0] paddr;
  logic [15:0] evt;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, checked, cyc, n;
  power_clock_mode_ctrl power_clock_mode_ctrl_i (.REF_CLK(ref_clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(rdy), .PSLVERR(err), .SUPPLY_BELOW_RESET(b_rst),
    .SUPPLY_BELOW_DETECT(b_det), .EXT_CLK_SAMPLE(ext_ck), .EXTERNAL_RESET_PIN_N(xrst_n),
    .WATCHDOG_RESET(wdg), .WAKEUP_PIN(wakeup_pin), .RTC_ALARM(rtc), .USB_WAKEUP(usb),
    .BOOT_SEL(boot_sel), .BANK2_OPTION(bank2), .EXTERNAL_EVENT_LINE(evt),
    .CPU_SLEEP_REQ(slp), .CPU_WAKE_EVENT(wev), .SYS_RESET_N(srst_n), .CPU_CLK_EN(cpu_en),
    .AHB_CLK_EN(), .APB_FAST_CLK_EN(), .APB_SLOW_CLK_EN(slow_en), .SYSCLK_SEL_EXT(sel_ext),
    .INTERNAL_FAST_RC_EN(rc_en), .EXTERNAL_FAST_OSC_EN(), .PLL_EN(pll_en),
    .MAIN_REGULATOR_EN(mr_en), .LOW_POWER_REGULATOR_EN(lpr_en), .REGULATOR_HIGH_Z(hiz),
    .LOW_SPEED_DOMAIN_RUN(lsd), .BOOT_TARGET(boot_t), .BOOT_BANK2(bank2_o),
    .MODE_STATE(mode), .IRQ(irq));
  // ----
  // Helpers
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (ext_run && cyc[1:0] == 2'h0) ext_ck <= ~ext_ck;
    if (cyc == 32'h0000_4E20) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (rdy !== 1'b1) @(posedge ref_clk);
    rd = err ? 32'hFFFF_FFFF : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_up();
    repeat (400) if (srst_n !== 1'b1) @(posedge ref_clk);
    chk(srst_n, 1'b1);
  endtask
  task automatic enter(input logic [31:0] cfg);
    apb(1'b1, pcm_pkg::OFS_PWR_CTRL, cfg);
    slp <= 1'b1;
    @(posedge ref_clk);
    slp <= 1'b0;
    tick(2);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_boot();
    chk({sel_ext, rc_en, mr_en, mode}, 6'h19);
    chk({boot_t, bank2_o}, 3'h2);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk(rd, 32'hFFFF_FFFF);
  endtask
  task automatic t_clk();
    ext_run <= 1'b1;
    apb(1'b1, pcm_pkg::OFS_CLK_CTRL, 32'h0000_0001);
    tick(40);
    apb(1'b1, pcm_pkg::OFS_CLK_CTRL, 32'h0000_0003);
    tick(3);
    chk(sel_ext, 1'b1);
    ext_run <= 1'b0;
    tick(300);
    chk({sel_ext, irq}, 2'h0);
    apb(1'b1, pcm_pkg::OFS_IRQ_EN, 32'h0000_0001);
    tick(2);
    chk(irq, 1'b1);
    apb(1'b1, pcm_pkg::OFS_IRQ_CLR, 32'h0000_0001);
    tick(2);
    chk(irq, 1'b0);
  endtask
  task automatic t_det();
    apb(1'b1, pcm_pkg::OFS_PWR_CTRL, 32'h0000_0003);
    b_det <= 1'b1;
    tick(10);
    apb(1'b1, pcm_pkg::OFS_PWR_CTRL, 32'h0000_0005);
    b_det <= 1'b0;
    tick(10);
    apb(1'b0, pcm_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
  endtask
  task automatic t_sleep();
    enter(32'h0000_0000);
    n = 0;
    repeat (16) @(posedge ref_clk) n += slow_en;
    chk({mode, 1'(n != 0)}, 4'h5);
    wev <= 1'b1;
    tick(1);
    wev <= 1'b0;
    tick(3);
    chk(mode, 3'h1);
  endtask
  task automatic t_stop();
    apb(1'b1, pcm_pkg::OFS_WAKE_EN, 32'h0000_0001);
    enter(32'h0000_0018);
    evt <= 16'h0002;
    tick(8);
    chk({mode, pll_en, lpr_en}, 5'hD);
    evt <= 16'h0001;
    tick(8);
    chk(mode, 3'h1);
    evt <= 16'h0000;
    apb(1'b0, pcm_pkg::OFS_WAKE_EN, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
  endtask
  task automatic t_stby();
    boot_sel <= 2'h0;
    enter(32'h0000_0020);
    chk({mode, hiz, mr_en, lsd, boot_t}, 8'h95);
    wakeup_pin <= 1'b1;
    tick(8);
    chk(srst_n, 1'b0);
    wait_up();
    chk({boot_t, bank2_o}, 3'h1);
    apb(1'b0, pcm_pkg::OFS_WAKE_EN, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wakeup_pin <= 1'b0;
    b_rst <= 1'b1;
    tick(6);
    chk(srst_n, 1'b0);
    b_rst <= 1'b0;
    wait_up();
  endtask
  task automatic print_verdict();
    $display("Mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, b_rst, b_det, ext_ck, wdg, wakeup_pin, rtc, usb, slp} = '0;
    {wev, ext_run, paddr, pwdata, evt, n_mismatch, checked, cyc} = '0;
    {xrst_n, bank2, boot_sel} = 4'hD;
    tick(3);
    rst_n <= 1'b1;
    wait_up();
    t_boot();
    t_clk();
    t_det();
    t_sleep();
    t_stop();
    t_stby();
    print_verdict();
  end
endmodule
bind power_clock_mode_ctrl pcm_sva pcm_sva_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .SUPPLY_BELOW_RESET(SUPPLY_BELOW_RESET), .EXT_CLK_SAMPLE(EXT_CLK_SAMPLE),
  .WAKEUP_PIN(WAKEUP_PIN), .SYS_RESET_N(SYS_RESET_N), .CPU_CLK_EN(CPU_CLK_EN),
  .SYSCLK_SEL_EXT(SYSCLK_SEL_EXT), .INTERNAL_FAST_RC_EN(INTERNAL_FAST_RC_EN),
  .EXTERNAL_FAST_OSC_EN(EXTERNAL_FAST_OSC_EN), .PLL_EN(PLL_EN),
  .MAIN_REGULATOR_EN(MAIN_REGULATOR_EN), .LOW_POWER_REGULATOR_EN(LOW_POWER_REGULATOR_EN),
  .REGULATOR_HIGH_Z(REGULATOR_HIGH_Z), .MODE_STATE(MODE_STATE));
`default_nettype wire
